// file: logic/psa_pkg.sv
package psa_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int POS_W = 40;
  localparam int SPD_W = 24;
  localparam int PER_W = 16;
  localparam int DIV_W = 8;
  localparam int RES_W = 6;
  localparam int CHUNK_W = 5;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAST_POSITION_BYTE4 = 8'h90;
  localparam logic [7:0] ADDR_POS3 = 8'h91;
  localparam logic [7:0] ADDR_POS2 = 8'h92;
  localparam logic [7:0] ADDR_POS1 = 8'h93;
  localparam logic [7:0] ADDR_FAST_POSITION_BYTE0 = 8'h94;
  localparam logic [7:0] ADDR_SPD2 = 8'h95;
  localparam logic [7:0] ADDR_SPD1 = 8'h96;
  localparam logic [7:0] ADDR_SPD0 = 8'h97;
  localparam logic [7:0] ADDR_SAFE4 = 8'h98;
  localparam logic [7:0] ADDR_SAFE3 = 8'h99;
  localparam logic [7:0] ADDR_SAFE2 = 8'h9a;
  localparam logic [7:0] ADDR_SAFE1 = 8'h9b;
  localparam logic [7:0] ADDR_SAFE0 = 8'h9c;
  localparam logic [7:0] ADDR_DUMMY = 8'hbf;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_REGISTER = 8'h80;
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h81;
  localparam logic [7:0] ADDR_EVENT_H = 8'h82;
  localparam logic [7:0] ADDR_ONLINE = 8'h83;
  localparam logic [7:0] ADDR_RES = 8'h84;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SYS_EDGE_BIT = 0;
  localparam int EVT_POS_ERR_BIT = 0;
  localparam int ONL_POSITION_ARRIVAL_BITS_LSB = 0;
  localparam int ONL_LOCK_BIT = 2;
  localparam int ONL_SYNC_BIT = 3;
  localparam logic [DIV_W-1:0] SYNC_DIV_RESET = 8'h00;
  localparam logic [RES_W-1:0] RES_RESET = 6'h28;
  localparam logic [RES_W-1:0] RES_FULL = 6'h28;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FRAME_MIN_NS = 11950;
  localparam int POS_DELAY_NS = 8000;
  localparam int FREE_FRAME_CYC = (FRAME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POS_DELAY_CYC = POS_DELAY_NS / CLK_PERIOD_NS;

endpackage

// file: logic/psa_period_div.sv
`timescale 1ns/1ps
module psa_period_div
  import psa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [PER_W-1:0] dividend,
  input wire logic [DIV_W-1:0] divisor,
  // answer
  output logic [PER_W-1:0] quotient,
  output logic done
);

  logic [PER_W-1:0] num_reg;
  logic [PER_W:0] rem_reg;
  logic [DIV_W-1:0] den_reg;
  logic [4:0] step_reg;
  logic busy_reg;
  logic [PER_W:0] trial;

  // restoring division, one quotient bit per clock
  assign trial = {rem_reg[PER_W-1:0], num_reg[PER_W-1]} - {{(PER_W+1-DIV_W){1'b0}}, den_reg};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      num_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      step_reg <= '0;
      busy_reg <= 1'b0;
      done <= 1'b0;
      quotient <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        num_reg <= dividend;
        rem_reg <= '0;
        den_reg <= divisor;
        step_reg <= 5'h10;
        busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (!trial[PER_W])
        begin
          rem_reg <= trial;
          num_reg <= {num_reg[PER_W-2:0], 1'b1};
        end
        else
        begin
          rem_reg <= {rem_reg[PER_W-1:0], num_reg[PER_W-1]};
          num_reg <= {num_reg[PER_W-2:0], 1'b0};
        end
        step_reg <= step_reg - 5'h01;
        if (step_reg == 5'h01)
        begin
          busy_reg <= 1'b0;
          done <= 1'b1;
          quotient <= {num_reg[PER_W-2:0], ~trial[PER_W]};
        end
      end
    end
  end

  logic [PER_W-1:0] dvd_hold;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dvd_hold <= '0;
    else if (start)
      dvd_hold <= dividend;
  end

  a_div_bound: assert property (@(posedge clk) disable iff (!rst_n)
    done && den_reg != '0 |-> ({8'h00, quotient} * {16'h0000, den_reg}) <= {8'h00, dvd_hold})
    else $error("interval times divider exceeds measured period");

endmodule // psa_period_div

// file: logic/psa_acquire.sv
`timescale 1ns/1ps
module psa_acquire
  import psa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // external sync pin
  input wire logic sync_in,
  // frame link logic
  output logic frame_trigger,
  input wire logic frame_valid,
  input wire logic [POS_W-1:0] frame_fast_pos,
  input wire logic [SPD_W-1:0] frame_speed,
  input wire logic frame_safe_start,
  input wire logic [CHUNK_W-1:0] frame_safe_chunk,
  // status
  output logic sync_locked
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic edge_sel_reg;
  logic [DIV_W-1:0] sync_div_reg;
  logic [RES_W-1:0] res_reg;
  logic sync_mode;
  logic [POS_W-1:0] res_mask;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edge_sel_reg <= 1'b0;
      sync_div_reg <= SYNC_DIV_RESET;
      res_reg <= RES_RESET;
    end
    else if (wr)
    begin
      if (addr == ADDR_SYSTEM_CONTROL_REGISTER)
        edge_sel_reg <= wdata[SYS_EDGE_BIT];
      if (addr == ADDR_SYNC_CTRL)
        sync_div_reg <= wdata;
      if (addr == ADDR_RES)
        res_reg <= (wdata[RES_W-1:0] > RES_FULL) ? RES_FULL : wdata[RES_W-1:0];
    end
  end

  assign sync_mode = (sync_div_reg != '0);

  // bits above the measured resolution forced to zero
  always_comb
  begin
    res_mask = '1;
    if (res_reg < RES_FULL)
      res_mask = (40'h00_0000_0001 << res_reg) - 40'h00_0000_0001;
  end

  // ----------------------------------------------------------------
  // sync pin
  // ----------------------------------------------------------------
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sync_s3_reg;
  logic sel_edge;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
    end
    else
    begin
      sync_s1_reg <= sync_in;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  // free running gates the pin off completely
  assign sel_edge = sync_mode && (edge_sel_reg ? (!sync_s2_reg && sync_s3_reg)
                                               : (sync_s2_reg && !sync_s3_reg));

  // ----------------------------------------------------------------
  // period measurement and interval
  // ----------------------------------------------------------------
  logic [PER_W-1:0] period_cnt_reg;
  logic edge_seen_reg;
  logic [PER_W-1:0] quotient;
  logic div_done;
  logic [PER_W-1:0] interval_reg;
  logic lock_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_cnt_reg <= '0;
      edge_seen_reg <= 1'b0;
    end
    else if (!sync_mode)
    begin
      period_cnt_reg <= '0;
      edge_seen_reg <= 1'b0;
    end
    else if (sel_edge)
    begin
      period_cnt_reg <= 16'h0001;
      edge_seen_reg <= 1'b1;
    end
    else if (period_cnt_reg != 16'hffff)
      period_cnt_reg <= period_cnt_reg + 16'h0001;
  end

  psa_period_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(sel_edge && edge_seen_reg),
    .dividend(period_cnt_reg),
    .divisor(sync_div_reg),
    .quotient(quotient),
    .done(div_done)
  );

  // lock once one full period has been measured and divided
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interval_reg <= 16'h0001;
      lock_reg <= 1'b0;
    end
    else if (!sync_mode)
      lock_reg <= 1'b0;
    else if (div_done)
    begin
      interval_reg <= (quotient == '0) ? 16'h0001 : quotient;
      lock_reg <= 1'b1;
    end
  end

  assign sync_locked = lock_reg;

  // ----------------------------------------------------------------
  // frame trigger
  // ----------------------------------------------------------------
  logic [PER_W-1:0] tick_reg;
  logic [DIV_W-1:0] sub_reg;
  logic [7:0] free_reg;
  logic sync_trig;
  logic free_trig;

  // trailing sub-frames run out on the count, a late edge restarts cleanly
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_reg <= '0;
      sub_reg <= '0;
    end
    else if (!lock_reg)
      sub_reg <= '0;
    else if (sel_edge)
    begin
      tick_reg <= interval_reg - 16'h0001;
      sub_reg <= sync_div_reg - 8'h01;
    end
    else if (sub_reg != '0)
    begin
      if (tick_reg == '0)
      begin
        tick_reg <= interval_reg - 16'h0001;
        sub_reg <= sub_reg - 8'h01;
      end
      else
        tick_reg <= tick_reg - 16'h0001;
    end
  end

  assign sync_trig = lock_reg && (sel_edge || (sub_reg != '0 && tick_reg == '0));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      free_reg <= '0;
    else if (sync_mode || free_reg == '0)
      free_reg <= 8'(FREE_FRAME_CYC - 1);
    else
      free_reg <= free_reg - 8'h01;
  end

  assign free_trig = !sync_mode && (free_reg == '0);
  assign frame_trigger = sync_trig || free_trig;

  // ----------------------------------------------------------------
  // fixed latency publish
  // ----------------------------------------------------------------
  logic [7:0] lat_reg;
  logic publish;
  logic pend_reg;
  logic [POS_W-1:0] pend_pos_reg;
  logic [SPD_W-1:0] pend_spd_reg;
  logic [POS_W-1:0] fast_pos_reg;
  logic [SPD_W-1:0] speed_reg;
  logic [1:0] position_arrival_bits_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lat_reg <= '0;
    else if (frame_trigger)
      lat_reg <= 8'(POS_DELAY_CYC);
    else if (lat_reg != '0)
      lat_reg <= lat_reg - 8'h01;
  end

  assign publish = (lat_reg == 8'h01);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg <= 1'b0;
      pend_pos_reg <= '0;
      pend_spd_reg <= '0;
    end
    else if (frame_valid)
    begin
      pend_reg <= 1'b1;
      pend_pos_reg <= frame_fast_pos & res_mask;
      pend_spd_reg <= frame_speed;
    end
    else if (publish)
      pend_reg <= 1'b0;
  end

  // a frame that misses its slot leaves the previous value standing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_pos_reg <= '0;
      speed_reg <= '0;
      position_arrival_bits_reg <= '0;
    end
    else if (publish && pend_reg)
    begin
      fast_pos_reg <= pend_pos_reg;
      speed_reg <= pend_spd_reg;
      position_arrival_bits_reg <= position_arrival_bits_reg + 2'b01;
    end
  end

  // ----------------------------------------------------------------
  // safe position over eight frames
  // ----------------------------------------------------------------
  logic [POS_W-1:0] safe_acc_reg;
  logic [2:0] safe_cnt_reg;
  logic safe_act_reg;
  logic [POS_W-1:0] safe_ref_reg;
  logic [POS_W-1:0] safe_pos_reg;
  logic [POS_W-1:0] safe_word;
  logic safe_load;
  logic pos_err_reg;

  assign safe_word = {frame_safe_chunk, safe_acc_reg[POS_W-1:CHUNK_W]};
  assign safe_load = frame_valid && safe_act_reg && safe_cnt_reg == 3'h7;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      safe_acc_reg <= '0;
      safe_cnt_reg <= '0;
      safe_act_reg <= 1'b0;
      safe_ref_reg <= '0;
    end
    else if (frame_valid)
    begin
      safe_acc_reg <= safe_word;
      if (frame_safe_start)
      begin
        safe_cnt_reg <= 3'h1;
        safe_act_reg <= 1'b1;
        safe_ref_reg <= frame_fast_pos & res_mask;
      end
      else if (safe_act_reg)
      begin
        safe_cnt_reg <= safe_cnt_reg + 3'h1;
        if (safe_cnt_reg == 3'h7)
          safe_act_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      safe_pos_reg <= '0;
    else if (safe_load)
      safe_pos_reg <= safe_word & res_mask;
  end

  // hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pos_err_reg <= 1'b0;
    else if (safe_load && ((safe_word & res_mask) != safe_ref_reg))
      pos_err_reg <= 1'b1;
    else if (wr && addr == ADDR_EVENT_H && wdata[EVT_POS_ERR_BIT])
      pos_err_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd)
    begin
      unique case (addr)
        ADDR_FAST_POSITION_BYTE4: rdata <= fast_pos_reg[39:32];
        ADDR_POS3: rdata <= fast_pos_reg[31:24];
        ADDR_POS2: rdata <= fast_pos_reg[23:16];
        ADDR_POS1: rdata <= fast_pos_reg[15:8];
        ADDR_FAST_POSITION_BYTE0: rdata <= fast_pos_reg[7:0];
        ADDR_SPD2: rdata <= speed_reg[23:16];
        ADDR_SPD1: rdata <= speed_reg[15:8];
        ADDR_SPD0: rdata <= speed_reg[7:0];
        ADDR_SAFE4: rdata <= safe_pos_reg[39:32];
        ADDR_SAFE3: rdata <= safe_pos_reg[31:24];
        ADDR_SAFE2: rdata <= safe_pos_reg[23:16];
        ADDR_SAFE1: rdata <= safe_pos_reg[15:8];
        ADDR_SAFE0: rdata <= safe_pos_reg[7:0];
        ADDR_SYSTEM_CONTROL_REGISTER: rdata <= {7'h00, edge_sel_reg};
        ADDR_SYNC_CTRL: rdata <= sync_div_reg;
        ADDR_EVENT_H: rdata <= {7'h00, pos_err_reg};
        ADDR_ONLINE: rdata <= {4'h0, sync_mode, lock_reg, position_arrival_bits_reg};
        ADDR_RES: rdata <= {2'b00, res_reg};
        default: rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [7:0] age_reg;
  logic [DIV_W-1:0] trig_in_per_reg;
  logic [3:0] safe_frames_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_reg <= '0;
      trig_in_per_reg <= '0;
      safe_frames_reg <= '0;
    end
    else
    begin
      age_reg <= frame_trigger ? 8'h01 : ((age_reg == 8'hff) ? age_reg : age_reg + 8'h01);
      trig_in_per_reg <= sel_edge ? 8'h01 : trig_in_per_reg + {7'h00, sync_trig};
      if (frame_valid)
        safe_frames_reg <= frame_safe_start ? 4'h1 : safe_frames_reg + 4'h1;
    end
  end

  a_free_no_sync: assert property (@(posedge clk) disable iff (!rst_n)
    free_trig |=> !frame_trigger [*8])
    else $error("extra trigger in free running mode");

  // judged from the synchronised pin itself, so a swapped polarity is caught
  a_edge_trigger: assert property (@(posedge clk) disable iff (!rst_n)
    sync_mode && lock_reg && (edge_sel_reg ? $fell(sync_s2_reg) : $rose(sync_s2_reg))
    |-> frame_trigger)
    else $error("selected sync edge gave no trigger");

  a_fixed_latency: assert property (@(posedge clk) disable iff (!rst_n)
    publish |-> age_reg == 8'(POS_DELAY_CYC))
    else $error("publish not at fixed delay after trigger");

  a_triggers_per_period: assert property (@(posedge clk) disable iff (!rst_n)
    sel_edge && lock_reg && $past(lock_reg) |-> trig_in_per_reg <= sync_div_reg)
    else $error("more triggers than divider in one period");

  a_position_arrival_bits_step: assert property (@(posedge clk) disable iff (!rst_n)
    publish && pend_reg |=> position_arrival_bits_reg == $past(position_arrival_bits_reg) + 2'b01)
    else $error("arrival bits did not advance");

  a_safe_eighth: assert property (@(posedge clk) disable iff (!rst_n)
    safe_load |-> safe_frames_reg == 4'h7)
    else $error("safe position not completed on eighth frame");

  a_pos_err_set: assert property (@(posedge clk) disable iff (!rst_n)
    safe_load && ((safe_word & res_mask) != safe_ref_reg) |=> pos_err_reg)
    else $error("mismatch did not raise position error");

  a_reset_free: assert property (@(posedge clk) $rose(rst_n) |-> !sync_mode)
    else $error("not free running after reset");

  a_high_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
    publish && pend_reg |=> (fast_pos_reg & ~$past(res_mask)) == '0)
    else $error("unmeasured position bits not zero");

  c_lock: cover property (@(posedge clk) disable iff (!rst_n) $rose(lock_reg));
  c_sync_sub: cover property (@(posedge clk) disable iff (!rst_n) sync_trig && !sel_edge);
  c_safe_load: cover property (@(posedge clk) disable iff (!rst_n) safe_load);
  c_pos_err: cover property (@(posedge clk) disable iff (!rst_n) $rose(pos_err_reg));

endmodule // psa_acquire

// file: verif/psa_link_model.sv
`timescale 1ns/1ps
module psa_link_model
  import psa_pkg::*;
#(
  parameter int REPLY_CYC = 20
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // frame link
  input wire logic frame_trigger,
  output logic frame_valid,
  output logic [POS_W-1:0] frame_fast_pos,
  output logic [SPD_W-1:0] frame_speed,
  output logic frame_safe_start,
  output logic [CHUNK_W-1:0] frame_safe_chunk,
  // test control and reference
  input wire logic corrupt,
  output logic [POS_W-1:0] last_pos,
  output logic [POS_W-1:0] safe_word
);
  int wait_cnt;
  int n;
  logic [POS_W-1:0] shift_word;
  logic [POS_W-1:0] held_word;
  logic [POS_W-1:0] pos_now;
  logic [POS_W-1:0] safe_now;

  assign pos_now = 40'h12_3456_0000 + 40'(n) * 40'h101;
  // corrupt flips the lsb of the safe copy only
  assign safe_now = pos_now ^ {39'h0, corrupt};

  // ----------------------------------------------------------------
  // frame reply
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_cnt <= 0;
      n <= 0;
      frame_valid <= 1'b0;
      frame_safe_start <= 1'b0;
      frame_fast_pos <= '0;
      frame_speed <= '0;
      frame_safe_chunk <= '0;
      shift_word <= '0;
      held_word <= '0;
      last_pos <= '0;
      safe_word <= '0;
    end
    else
    begin
      frame_valid <= 1'b0;
      frame_safe_start <= 1'b0;
      // idle data lines keep changing so stale values never look valid
      frame_fast_pos <= ~frame_fast_pos;
      frame_speed <= ~frame_speed;
      frame_safe_chunk <= ~frame_safe_chunk;
      if (frame_trigger)
        wait_cnt <= REPLY_CYC;
      else if (wait_cnt > 0)
        wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1)
      begin
        frame_valid <= 1'b1;
        frame_fast_pos <= pos_now;
        frame_speed <= pos_now[23:0] ^ 24'h0a0000;
        last_pos <= pos_now;
        n <= n + 1;
        if (n % 8 == 0)
        begin
          frame_safe_start <= 1'b1;
          frame_safe_chunk <= safe_now[4:0];
          shift_word <= safe_now >> 5;
          held_word <= safe_now;
        end
        else
        begin
          frame_safe_chunk <= shift_word[4:0];
          shift_word <= shift_word >> 5;
        end
        if (n % 8 == 7)
          safe_word <= held_word;
      end
    end
  end
endmodule // psa_link_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import psa_pkg::*;
  logic clk, rst_b, wr, rd, sync_in, sync_run, corrupt;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d, cnt0;
  logic frame_trigger, frame_valid, frame_safe_start, sync_locked;
  logic [POS_W-1:0] frame_fast_pos, last_pos, safe_word, word;
  logic [SPD_W-1:0] frame_speed;
  logic [CHUNK_W-1:0] frame_safe_chunk;
  logic [1:0] cexp;
  int miscompares = 0;
  int n_checks = 0;
  int sp = 0;
  int gap;

  psa_acquire u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sync_in(sync_in), .frame_trigger(frame_trigger), .frame_valid(frame_valid),
    .frame_fast_pos(frame_fast_pos), .frame_speed(frame_speed),
    .frame_safe_start(frame_safe_start), .frame_safe_chunk(frame_safe_chunk),
    .sync_locked(sync_locked));

  psa_link_model u_link (.clk(clk), .rst_b(rst_b), .frame_trigger(frame_trigger),
    .frame_valid(frame_valid), .frame_fast_pos(frame_fast_pos), .frame_speed(frame_speed),
    .frame_safe_start(frame_safe_start), .frame_safe_chunk(frame_safe_chunk),
    .corrupt(corrupt), .last_pos(last_pos), .safe_word(safe_word));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // sync pin: 50 us period, high 10 us, runs from time zero
  always @(posedge clk)
  begin
    sp <= (sp == 499) ? 0 : sp + 1;
    sync_in <= sync_run && (sp < 100);
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic rd_word(input logic [7:0] a, output logic [39:0] w);
    logic [7:0] b;
    w = '0;
    for (int i = 0; i < 5; i++)
    begin
      rd_reg(a + 8'(i), b);
      w = {w[31:0], b};
    end
  endtask

  task automatic chk_spd;
    logic [7:0] b;
    logic [23:0] s;
    s = '0;
    for (int i = 0; i < 3; i++)
    begin
      rd_reg(ADDR_SPD2 + 8'(i), b);
      s = {s[15:0], b};
    end
    chk(s, last_pos[23:0] ^ 24'h0a0000);
    repeat (2)
    begin
      rd_reg(ADDR_DUMMY, b);
      chk(b, 8'h00);
    end
  endtask

  // cycles counted up to and including the next trigger cycle
  task automatic wait_trig(output int c);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end
    while (frame_trigger !== 1'b1 && c < 2000);
    if (c >= 2000)
    begin
      miscompares++;
      print_verdict();
    end
  endtask

  // publication lands 80 cycles after the trigger; margin of 5
  task automatic after_pub;
    int c;
    wait_trig(c);
    repeat (85) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    sync_run = 1'b1;
    corrupt = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(ADDR_SYNC_CTRL, d);
    chk(d, SYNC_DIV_RESET);
    rd_reg(ADDR_RES, d);
    chk(d, RES_RESET);
    rd_reg(ADDR_ONLINE, d);
    chk(d[3], 1'b0);
    wr_reg(8'h7e, 8'h55);
    rd_reg(8'h7e, d);
    chk(d, 8'h00);
    // sync pin toggles all along; free framing must not follow it
    wait_trig(gap);
    wait_trig(gap);
    chk(gap, FREE_FRAME_CYC);
    after_pub;
    rd_reg(ADDR_ONLINE, cnt0);
    after_pub;
    rd_reg(ADDR_ONLINE, d);
    cexp = cnt0[1:0] + 2'h1;
    chk(d[1:0], cexp);
    rd_word(ADDR_FAST_POSITION_BYTE4, word);
    chk(word, last_pos);
    chk_spd();
    rd_reg(ADDR_FAST_POSITION_BYTE0, d);
    chk(d, last_pos[7:0]);
    repeat (17) after_pub;
    rd_word(ADDR_SAFE4, word);
    chk(word, safe_word);
    rd_reg(ADDR_EVENT_H, d);
    chk(d[0], 1'b0);
    corrupt <= 1'b1;
    repeat (17) after_pub;
    rd_reg(ADDR_EVENT_H, d);
    chk(d[0], 1'b1);
    corrupt <= 1'b0;
    repeat (17) after_pub;
    rd_reg(ADDR_EVENT_H, d);
    chk(d[0], 1'b1);
    wr_reg(ADDR_EVENT_H, 8'h01);
    rd_reg(ADDR_EVENT_H, d);
    chk(d[0], 1'b0);
    wr_reg(ADDR_RES, 8'h11);
    after_pub;
    rd_word(ADDR_FAST_POSITION_BYTE4, word);
    chk(word, last_pos & 40'h1_ffff);
    wr_reg(ADDR_RES, 8'h3f);
    rd_reg(ADDR_RES, d);
    chk(d, 8'h28);
    // falling edge, divider 2: 25 us frames, kept until the divider is cleared to 0 further down
    wr_reg(ADDR_SYSTEM_CONTROL_REGISTER, 8'h01);
    wr_reg(ADDR_SYNC_CTRL, 8'h02);
    for (gap = 0; gap < 3000 && sync_locked !== 1'b1; gap++)
      @(negedge clk);
    chk(sync_locked, 1'b1);
    if (sync_locked !== 1'b1)
      print_verdict();
    rd_reg(ADDR_ONLINE, d);
    chk(d[3:2], 2'b11);
    wait_trig(gap);
    wait_trig(gap);
    chk(gap, 250);
    wait_trig(gap);
    chk(gap, 250);
    // falling edge sits at phase 100; a rising-edge trigger would land near 0
    chk((sp % 250 >= 101) && (sp % 250 <= 108), 1'b1);
    after_pub;
    chk_spd();
    wr_reg(ADDR_SYNC_CTRL, 8'h00);
    // lock register drops on the edge after the divider write lands
    repeat (2) @(negedge clk);
    chk(sync_locked, 1'b0);
    rd_reg(ADDR_ONLINE, d);
    chk(d[3], 1'b0);
    print_verdict();
  end
endmodule // tb_top
